// File: pkg/port_status_pkg.sv
/*
 * constants for the port status and parameter register bank: offsets,
 * field positions, reset values, quiet slot table and port states.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package port_status_pkg;
    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] OFF_PARAMS = 13'h00f8;
    localparam logic [12:0] OFF_ERR_DETAIL = 13'h00fc;
    localparam logic [12:0] OFF_INT_STATUS = 13'h1000;
    localparam logic [12:0] OFF_MAINT_CTRL = 13'h1004;
    // --------------------------------------------------------------
    // parameter register fields
    // --------------------------------------------------------------
    localparam logic [12:0] LEN_VALUE = 13'h0ff8;
    localparam int ARB_DEFEAT_BIT = 12;
    localparam int EXT_HEADER_BIT = 11;
    localparam logic [7:0] NODE_RST = 8'h00;
    localparam logic [2:0] QS_SEL_RST = 3'h0;
    localparam logic [2:0] QS_ILLEGAL = 3'h7;
    localparam int QS_W = 6;
    localparam logic [5:0] QS_DEFEAT = 6'h01;
    localparam logic [5:0] QS_TABLE [0:6] = '{6'h07, 6'h0a, 6'h0e, 6'h10, 6'h15, 6'h19, 6'h20};
    // --------------------------------------------------------------
    // interrupt status fields; event vector bits 8:0 sit at the same places
    // --------------------------------------------------------------
    localparam int EV_W = 9;
    localparam int SUMMARY_BIT = 15;
    localparam int UNINIT_BIT = 10;
    localparam int INT_FLAG_BIT = 9;
    localparam int EV_HW_FAIL = 8;
    localparam int EV_MISC = 7;
    localparam int EV_TIMER = 6;
    localparam int EV_BUS_ERR = 5;
    localparam int EV_DATA_ERR = 4;
    localparam int EV_INIT_DONE = 3;
    localparam int EV_DIS_DONE = 2;
    localparam int EV_FREEQ = 1;
    localparam int EV_RSP = 0;
    localparam logic [8:0] SUMMARY_MASK = 9'h1fe;
    // --------------------------------------------------------------
    // maintenance control fields
    // --------------------------------------------------------------
    localparam int MC_PAR_LSB = 9;
    localparam int PAR_W = 7;
    localparam int MC_HALT_BIT = 7;
    localparam int MC_INT_EN_BIT = 5;
    localparam int MC_MTD_BIT = 1;
    // --------------------------------------------------------------
    // port states, one-hot
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_UNINIT = 3'b001,
        ST_DISABLED = 3'b010,
        ST_ENABLED = 3'b100
    } port_state_t;
endpackage
`default_nettype wire

// File: pkg/status_event_if.sv
/*
 * carrier between the register bank and its status latch.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface status_event_if;
    logic [8:0] ev;      // one-cycle event pulses
    logic release_wr;    // driver released the status register
    logic uninitialized_flag;          // live uninitialized level
    logic frozen;        // status held for the driver
    logic [31:0] status_word; // status word as read
    modport src (output ev, output release_wr, output uninitialized_flag, input frozen, input status_word);
    modport latch (input ev, input release_wr, input uninitialized_flag, output frozen, output status_word);
endinterface
`default_nettype wire

// File: logic/status_latch.sv
/*
 * status latch: gathers event pulses, freezes the status word once an
 * interrupt is requested and queues later events until release.
 * assumes events are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module status_latch
    import port_status_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // event carrier
    status_event_if.latch ifc
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [8:0] pend;  // events seen while frozen
        logic [8:0] evt;   // latched event bits
        logic uninitialized_flag;        // latched uninitialized bit
        logic frozen;      // interrupt requested, not yet released
    } latch_t;
    latch_t q;
    latch_t d;
    logic summary;

    // next state of the latch
    always_comb begin
        d = q;
        if (q.frozen) begin
            // set wins: events in the release cycle are queued
            d.pend = q.pend | ifc.ev;
            if (ifc.release_wr) begin
                d.frozen = 1'b0;
                d.evt = '0;
                d.uninitialized_flag = ifc.uninitialized_flag;
            end
        end else begin
            d.uninitialized_flag = ifc.uninitialized_flag;
            if (|(q.pend | ifc.ev)) begin
                d.evt = q.pend | ifc.ev;
                d.frozen = 1'b1;
                d.pend = '0;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q <= '{pend: '0, evt: '0, uninitialized_flag: 1'b1, frozen: 1'b0};
        end else begin
            q <= d;
        end
    end

    // summary excludes the response bit
    assign summary = q.uninitialized_flag | (|(q.evt & SUMMARY_MASK));
    assign ifc.frozen = q.frozen;
    assign ifc.status_word = {16'h0000, summary, 4'h0, q.uninitialized_flag, q.frozen, q.evt};

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.frozen && !ifc.release_wr) |=> $stable(ifc.status_word))
        else $error("status changed while frozen");
    AST_REPOST: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.frozen && ifc.release_wr && (|q.pend)) |=> !q.frozen ##1 q.frozen)
        else $error("queued event not reposted after release");
    AST_RSP_ONLY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (!q.frozen && q.pend == 9'h000 && ifc.ev == 9'h001)
        |=> (ifc.status_word[EV_RSP] && ifc.status_word[SUMMARY_BIT] == ifc.status_word[UNINIT_BIT]))
        else $error("response bit set the summary bit");
endmodule // status_latch
`default_nettype wire

// File: logic/port_status_regs.sv
/*
 * port parameter, error detail, interrupt status and maintenance control
 * registers of a cluster port adapter, with the port state machine.
 * assumes microcode and link logic on the same clock drive the event
 * pulses, and the host register access arrives as single-cycle strobes.
 */


`timescale 1ns/1ps
`default_nettype none
module port_status_regs
    import port_status_pkg::*;
#(
    parameter int PAR_N = PAR_W,   // number of parity flags
    parameter int BUS_ERR_N = 4    // hardware error bits of the bus error register
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // host register access
    input wire logic i_reg_rd,
    input wire logic i_reg_wr,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    // host command strobes
    input wire logic i_status_release,
    input wire logic i_init_cmd,
    // microcode parameter load
    input wire logic i_param_load,
    input wire logic [7:0] i_param_node,
    input wire logic i_param_arb_defeat,
    input wire logic i_param_ext_header,
    input wire logic [2:0] i_param_quiet_sel,
    // microcode and hardware events
    input wire logic [PAR_N-1:0] i_parity_err,
    input wire logic i_misc_err,
    input wire logic i_sanity_expire,
    input wire logic i_boot_timeout,
    input wire logic [BUS_ERR_N-1:0] i_bus_hw_err,
    input wire logic i_ds_err,
    input wire logic [31:0] i_err_detail,
    input wire logic i_init_done,
    input wire logic i_disable_done,
    input wire logic i_enable_cmd,
    input wire logic i_mfq_empty,
    input wire logic i_rsp_queued,
    input wire logic i_maint_class_en,
    // link controls
    output logic [QS_W-1:0] o_quiet_slots,
    output logic o_quiet_illegal,
    output logic o_arb_defeat,
    output logic o_ext_header,
    output logic [7:0] o_node,
    output logic o_link_accept,
    output logic o_link_maint_accept,
    // port control and interrupt
    output logic [2:0] o_port_state,
    output logic o_ucode_halt,
    output logic o_cmd_queue_run,
    output logic o_irq
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        port_state_t state;        // port operating state
        logic halt;                // microcode halted, slave only
        logic [7:0] node;          // node number
        logic arb_defeat;          // arbitration defeat
        logic ext_header;          // extended header
        logic [2:0] qs_sel;        // quiet slot select code
        logic [QS_W-1:0] quiet;    // quiet slot count to the link
        logic [31:0] err_detail;   // error detail capture
        logic int_en;              // maintenance interrupt enable
        logic mtd;                 // maintenance timer disable
        logic [PAR_N-1:0] par;     // sticky parity flags
        logic bus_err_seen;        // bus error level already flagged
        logic [31:0] rdata;        // read data
    } regs_t;

    localparam regs_t REGS_RST = '{
        state: ST_UNINIT,
        halt: 1'b0,
        node: NODE_RST,
        arb_defeat: 1'b0,
        ext_header: 1'b0,
        qs_sel: QS_SEL_RST,
        quiet: QS_TABLE[0],
        err_detail: 32'h0000_0000,
        int_en: 1'b0,
        mtd: 1'b0,
        par: '0,
        bus_err_seen: 1'b0,
        rdata: 32'h0000_0000
    };

    regs_t q;
    regs_t d;
    status_event_if ifc ();

    // event terms
    logic hw_fail_ev; // a new parity flag set
    logic timer_ev; // enabled timer expired
    logic bus_err_ev; // bus hardware error newly seen
    logic disable_ev; // any cause that leaves the port disabled

    // read words built from the stored fields
    logic [31:0] param_word; // parameter register as read
    logic [31:0] mc_word; // maintenance control as read

    // --------------------------------------------------------------
    // status latch
    // --------------------------------------------------------------
    // the latch owns the frozen status word and the repost queue
    status_latch status_latch_inst (
        .i_clk (i_clk),
        .i_rst_b (i_rst_b),
        .ifc (ifc)
    );

    // events towards the latch; each term is a one-cycle pulse
    always_comb begin
        // only a flag that was clear counts, so a stuck flag fires once
        hw_fail_ev = |(i_parity_err & ~q.par);
        // timers are ignored while the timer disable bit is set
        timer_ev = (i_sanity_expire | i_boot_timeout) & ~q.mtd;
        // the bus error bits are levels; only the rising edge is an event
        bus_err_ev = (|i_bus_hw_err) & ~q.bus_err_seen;
        disable_ev = i_misc_err | bus_err_ev | i_ds_err | i_init_done | i_disable_done;
        ifc.ev = '0;
        ifc.ev[EV_HW_FAIL] = hw_fail_ev;
        ifc.ev[EV_MISC] = i_misc_err;
        ifc.ev[EV_TIMER] = timer_ev;
        ifc.ev[EV_BUS_ERR] = bus_err_ev;
        ifc.ev[EV_DATA_ERR] = i_ds_err;
        ifc.ev[EV_INIT_DONE] = i_init_done;
        ifc.ev[EV_DIS_DONE] = i_disable_done;
        ifc.ev[EV_FREEQ] = i_mfq_empty;
        ifc.ev[EV_RSP] = i_rsp_queued;
        ifc.release_wr = i_status_release;
        // a failure or expiry must already show uninitialized in the word it freezes
        ifc.uninitialized_flag = (q.state == ST_UNINIT) || hw_fail_ev || timer_ev;
    end

    // --------------------------------------------------------------
    // read words
    // --------------------------------------------------------------
    // parameter word; bits 31:29 and 15:13 read zero
    always_comb begin
        param_word = 32'h0000_0000;
        // buffer length is a constant, not a stored field
        param_word[28:16] = LEN_VALUE;
        param_word[ARB_DEFEAT_BIT] = q.arb_defeat;
        param_word[EXT_HEADER_BIT] = q.ext_header;
        // the select code reads back as loaded, the illegal one too
        param_word[10:8] = q.qs_sel;
        param_word[7:0] = q.node;
    end

    // maintenance control word; reserved bits read zero
    always_comb begin
        mc_word = 32'h0000_0000;
        mc_word[MC_PAR_LSB +: PAR_N] = q.par;
        mc_word[MC_HALT_BIT] = q.halt;
        mc_word[MC_INT_EN_BIT] = q.int_en;
        mc_word[MC_MTD_BIT] = q.mtd;
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        // parity flags stay set; only reset clears them
        d.par = q.par | i_parity_err;
        d.bus_err_seen = |i_bus_hw_err;
        // microcode loads the parameters during initialization
        if (i_param_load) begin
            d.node = i_param_node;
            d.arb_defeat = i_param_arb_defeat;
            d.ext_header = i_param_ext_header;
            d.qs_sel = i_param_quiet_sel;
        end

        // quiet slot count follows the parameter fields
        if (d.arb_defeat) begin
            // defeat overrides the select code with one basic slot
            d.quiet = QS_DEFEAT;
        end else if (d.qs_sel == QS_ILLEGAL) begin
            // illegal code: zero, and the link sees the illegal flag
            d.quiet = '0;
        end else begin
            d.quiet = QS_TABLE[d.qs_sel];
        end
        // error detail captured with its error
        if (i_ds_err || i_misc_err) begin
            d.err_detail = i_err_detail;
        end

        // port state; hardware failure and timers win
        if (hw_fail_ev) begin
            // failure: microcode stops, only slave access remains
            d.state = ST_UNINIT;
            d.halt = 1'b1;
        end else if (timer_ev) begin
            // timer expiry drops back to uninitialized
            d.state = ST_UNINIT;
        end else if (q.state == ST_UNINIT) begin
            // only the initialize command leaves this state
            if (i_init_cmd) begin
                d.state = ST_DISABLED;
                d.halt = 1'b0;
            end
        end else if (disable_ev) begin
            // every error or completion cause parks the port disabled
            d.state = ST_DISABLED;
        end else if (q.state == ST_DISABLED && i_enable_cmd) begin
            // enable resumes command queues and traffic
            d.state = ST_ENABLED;
        end

        // host writes; only maintenance control takes them
        if (i_reg_wr) begin
            if (i_reg_addr == OFF_MAINT_CTRL) begin
                d.int_en = i_reg_wdata[MC_INT_EN_BIT];
                d.mtd = i_reg_wdata[MC_MTD_BIT];
            end
            // other offsets are read only; status writes are dropped
        end
        // host reads, answered at the next edge
        if (i_reg_rd) begin
            if (i_reg_addr == OFF_PARAMS) begin
                d.rdata = param_word;
            end else if (i_reg_addr == OFF_ERR_DETAIL) begin
                d.rdata = q.err_detail;
            end else if (i_reg_addr == OFF_INT_STATUS) begin
                // the latch holds this word steady while frozen
                d.rdata = ifc.status_word;
            end else if (i_reg_addr == OFF_MAINT_CTRL) begin
                d.rdata = mc_word;
            end else begin
                d.rdata = 32'h0000_0000;
            end
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q <= REGS_RST;
        end else begin
            q <= d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign o_reg_rdata = q.rdata;
    assign o_quiet_slots = q.quiet;
    assign o_quiet_illegal = (q.qs_sel == QS_ILLEGAL);
    assign o_arb_defeat = q.arb_defeat;
    assign o_ext_header = q.ext_header;
    assign o_node = q.node;
    // uninitialized ignores all traffic, disabled only maintenance class
    assign o_link_accept = (q.state == ST_ENABLED);
    assign o_link_maint_accept = (q.state == ST_DISABLED) && i_maint_class_en;
    assign o_port_state = q.state;
    assign o_ucode_halt = q.halt;
    assign o_cmd_queue_run = (q.state == ST_ENABLED) && !q.halt;
    // request held from latch until release, gated by enable
    assign o_irq = ifc.frozen && q.int_en;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_LEN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == OFF_PARAMS) |=> (o_reg_rdata[28:16] == 13'h0ff8))
        else $error("length field not fixed");
    AST_ARB: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        o_arb_defeat |-> (o_quiet_slots == 6'h01))
        else $error("defeat did not force one quiet slot");
    AST_EXT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_param_load && i_param_ext_header) |=> o_ext_header)
        else $error("extended header not taken");
    AST_QS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_param_load && !i_param_arb_defeat && i_param_quiet_sel == 3'h6) |=> (o_quiet_slots == 6'h20))
        else $error("quiet slot code six not 32");
    AST_NODE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_reg_rd && i_reg_addr == OFF_PARAMS) |=> (o_reg_rdata[7:0] == $past(o_node)))
        else $error("node number misread");
    AST_MTE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        hw_fail_ev |=> (o_port_state == ST_UNINIT && o_ucode_halt && !o_cmd_queue_run))
        else $error("hardware failure did not halt port");
    AST_DSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_ds_err && !hw_fail_ev && !timer_ev && q.state != ST_UNINIT) |=> (o_port_state == ST_DISABLED))
        else $error("data structure error left port enabled");

    AST_TIMER: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        timer_ev |=> (o_port_state == ST_UNINIT && !o_link_accept))
        else $error("timer expiry did not uninitialize port");

    AST_BUSERR: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (bus_err_ev && !hw_fail_ev && !timer_ev && q.state != ST_UNINIT) |=> (o_port_state == ST_DISABLED))
        else $error("bus hardware error left port enabled");

    AST_INIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (q.state == ST_UNINIT && i_init_cmd && !hw_fail_ev && !timer_ev)
        |=> (o_port_state == ST_DISABLED && !o_ucode_halt))
        else $error("initialize did not leave uninitialized state");

    AST_UNINITIALIZED_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_port_state == ST_UNINIT) |-> (!o_link_accept && !o_link_maint_accept))
        else $error("uninitialized port accepts traffic");
    AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (o_irq && !i_status_release) |=> o_irq)
        else $error("interrupt dropped before release");
    AST_GATE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (|ifc.ev && !ifc.frozen && !q.int_en && !i_reg_wr) |=> (ifc.frozen && !o_irq))
        else $error("masked condition not flagged or delivered");
endmodule // port_status_regs
`default_nettype wire

// File: dv/port_status_and_parameters_bench.sv
/*
 * self-checking bench for the port status and parameter register bank.
 * assumes the register bank package and a 40 MHz clock; reads are noted in
 * a queue by the driver and compared by a monitor one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module port_status_and_parameters_bench;
    import port_status_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ----------------------------------------------------------------
    localparam logic [11:0] MISC = 12'h001, SAN = 12'h002, BOOT = 12'h004, DS = 12'h008;
    localparam logic [11:0] IDONE = 12'h010, DDONE = 12'h020, EN = 12'h040, MFQ = 12'h080;
    localparam logic [11:0] RSP = 12'h100, INIT = 12'h200, REL = 12'h400, LD = 12'h800;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic rd = 1'b0, wr = 1'b0, arb = 1'b0, ext = 1'b0, mce = 1'b0, pend = 1'b0;
    logic [12:0] addr = 13'h0000;
    logic [31:0] wdata = 32'h0, rnd = 32'h0, rdata;
    logic [11:0] evs = 12'h000; // one-cycle event and command strobes
    logic [6:0] par = 7'h00;
    logic [3:0] bus = 4'h0;
    logic [2:0] qs = 3'h0, st;
    logic [5:0] qsl;
    logic [7:0] nodo;
    logic qill, arbo, exto, lacc, lmacc, halt, run, irq;
    logic [5:0] qtab [0:7] = '{6'h07, 6'h0a, 6'h0e, 6'h10, 6'h15, 6'h19, 6'h20, 6'h00};
    logic [11:0] kev [0:3] = '{MISC, IDONE, DDONE, RSP};
    logic [31:0] kst [0:3] = '{32'h0000_8280, 32'h0000_8208, 32'h0000_8204, 32'h0000_0201};
    logic [31:0] expq [$]; // expected read data, oldest first
    int seed = 92;
    int miscompares = 0;
    int total_checks = 0;
    // clock at 25 ns period
    always #12.5 i_clk = ~i_clk;
    port_status_regs port_status_regs_inst (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_status_release(evs[10]), .i_init_cmd(evs[9]),
        .i_param_load(evs[11]), .i_param_node(rnd[7:0]), .i_param_arb_defeat(arb), .i_param_ext_header(ext),
        .i_param_quiet_sel(qs), .i_parity_err(par), .i_misc_err(evs[0]), .i_sanity_expire(evs[1]),
        .i_boot_timeout(evs[2]), .i_bus_hw_err(bus), .i_ds_err(evs[3]), .i_err_detail(rnd),
        .i_init_done(evs[4]), .i_disable_done(evs[5]), .i_enable_cmd(evs[6]), .i_mfq_empty(evs[7]),
        .i_rsp_queued(evs[8]), .i_maint_class_en(mce), .o_quiet_slots(qsl), .o_quiet_illegal(qill),
        .o_arb_defeat(arbo), .o_ext_header(exto), .o_node(nodo), .o_link_accept(lacc),
        .o_link_maint_accept(lmacc), .o_port_state(st), .o_ucode_halt(halt), .o_cmd_queue_run(run),
        .o_irq(irq)
    );
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // read strobe for one cycle, answer noted for the monitor
    task automatic rdr(input logic [12:0] a, input logic [31:0] e);
        cyc(1);
        rd = 1'b1;
        addr = a;
        expq.push_back(e);
        cyc(1);
        rd = 1'b0;
    endtask
    task automatic wrr(input logic [12:0] a, input logic [31:0] d);
        cyc(1);
        wr = 1'b1;
        addr = a;
        wdata = d;
        cyc(1);
        wr = 1'b0;
    endtask
    // pulse strobes and parity flags; returns after the status has loaded
    task automatic ev(input logic [11:0] m, input logic [6:0] p = 7'h00);
        cyc(1);
        evs = m;
        par = p;
        cyc(1);
        evs = '0;
        par = '0;
        cyc(1);
    endtask
    task automatic rls;
        ev(REL);
        cyc(1);
    endtask
    // halt, queue run, link accept, irq and port state together
    task automatic stat(input logic [6:0] e);
        chk(32'({halt, run, lacc, irq, st}), 32'(e));
    endtask
    task automatic tend(input string s);
        $display("test %0s done", s);
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // monitor: read data appears at the edge that samples the read, checked half a cycle later
    // ----------------------------------------------------------------
    always @(posedge i_clk) pend <= rd;
    always @(negedge i_clk) begin
        if (pend) begin
            chk(rdata, expq.pop_front());
        end
    end
    // watchdog cuts a hang short well past the expected run length
    initial begin
        cyc(4000);
        miscompares++;
        test_done;
    end
    // ----------------------------------------------------------------
    // scenarios; the bench never writes the status word
    // ----------------------------------------------------------------
    initial begin
        cyc(16);
        i_rst_b = 1'b1;
        stat({4'b0000, ST_UNINIT});
        chk(32'(qsl), 32'h0000_0007);
        rdr(OFF_INT_STATUS, 32'h0000_8400);
        rdr(OFF_PARAMS, 32'h0ff8_0000);
        rdr(13'h0004, 32'h0000_0000);
        tend("reset");
        // every select code, then arbitration defeat
        for (int k = 0; k < 9; k++) begin
            rnd = $random(seed);
            qs = k[2:0];
            ext = k[0];
            arb = (k == 8);
            ev(LD);
            chk(32'({qill, exto, arbo, qsl}), 32'({k == 7, k[0], k == 8, k == 8 ? 6'h01 : qtab[k[2:0]]}));
            chk(32'(nodo), 32'(rnd[7:0]));
            rdr(OFF_PARAMS, {3'h0, 13'h0ff8, 3'h0, k == 8, k[0], k[2:0], rnd[7:0]});
        end
        wrr(OFF_PARAMS, 32'hffff_ffff);
        rdr(OFF_PARAMS, {16'h0ff8, 8'h10, rnd[7:0]});
        tend("params");
        // freeze, hold while a later event queues, then repost
        wrr(OFF_MAINT_CTRL, 32'h0000_0020);
        mce = 1'b1;
        ev(INIT);
        stat({4'b0000, ST_DISABLED});
        rnd = $random(seed);
        ev(DS);
        stat({4'b0001, ST_DISABLED});
        chk(32'(lmacc), 32'h0000_0001);
        rdr(OFF_ERR_DETAIL, rnd);
        rdr(OFF_INT_STATUS, 32'h0000_8210);
        ev(MFQ);
        rdr(OFF_INT_STATUS, 32'h0000_8210);
        rls;
        stat({4'b0001, ST_DISABLED});
        rdr(OFF_INT_STATUS, 32'h0000_8202);
        rls;
        stat({4'b0000, ST_DISABLED});
        rdr(OFF_INT_STATUS, 32'h0000_0000);
        tend("freeze");
        // each remaining cause but timers and parity in turn
        for (int k = 0; k < 4; k++) begin
            ev(kev[k]);
            stat({4'b0001, ST_DISABLED});
            rdr(OFF_INT_STATUS, kst[k]);
            rls;
        end
        ev(EN);
        stat({4'b0110, ST_ENABLED});
        bus = 4'h2;
        cyc(2);
        stat({4'b0001, ST_DISABLED});
        rdr(OFF_INT_STATUS, 32'h0000_8220);
        bus = 4'h0;
        rls;
        tend("causes");
        // delivery gated off, flag still shown
        wrr(OFF_MAINT_CTRL, 32'h0000_0000);
        ev(RSP);
        stat({4'b0000, ST_DISABLED});
        rdr(OFF_INT_STATUS, 32'h0000_0201);
        rls;
        for (int k = 0; k < 2; k++) begin
            ev(k == 0 ? SAN : BOOT);
            stat({4'b0000, ST_UNINIT});
            rdr(OFF_INT_STATUS, 32'h0000_8640);
            rls;
            ev(INIT);
        end
        // timer disable masks an expiry
        wrr(OFF_MAINT_CTRL, 32'h0000_0002);
        rdr(OFF_MAINT_CTRL, 32'h0000_0002);
        ev(SAN);
        stat({4'b0000, ST_DISABLED});
        tend("timers");
        // parity fault halts, flags outlive the release
        wrr(OFF_MAINT_CTRL, 32'h0000_0020);
        ev(12'h000, 7'h04);
        stat({4'b1001, ST_UNINIT});
        rdr(OFF_INT_STATUS, 32'h0000_8700);
        rdr(OFF_MAINT_CTRL, 32'h0000_08a0);
        rls;
        rdr(OFF_MAINT_CTRL, 32'h0000_08a0);
        rdr(OFF_INT_STATUS, 32'h0000_8400);
        ev(INIT);
        stat({4'b0000, ST_DISABLED});
        tend("parity");
        test_done;
    end
endmodule // port_status_and_parameters_bench
`default_nettype wire
